// File: pkg/upm_pkg.sv
// package: constants and types for the unattached switch port controller
package upm_pkg;
    // port modes from the switch port control mode field
    typedef enum logic [2:0] {
        UPM_MODE_DISABLED   = 3'h0,
        UPM_MODE_UNATTACHED = 3'h1,
        UPM_MODE_UPSTREAM   = 3'h2,
        UPM_MODE_DOWNSTREAM = 3'h3
    } upm_mode_t;

    // link training state as seen by this block
    typedef enum logic [1:0] {
        UPM_LT_DETECT   = 2'h0,
        UPM_LT_TRAINING = 2'h1,
        UPM_LT_L0       = 2'h2
    } upm_lt_t;

    // received transaction kinds
    typedef enum logic [1:0] {
        UPM_RX_CFG  = 2'h0,
        UPM_RX_REQ  = 2'h1,
        UPM_RX_NPR  = 2'h2,
        UPM_RX_CPL  = 2'h3
    } upm_rx_t;

    // completion status
    typedef enum logic [2:0] {
        UPM_CPL_SC  = 3'h0,
        UPM_CPL_UR  = 3'h1,
        UPM_CPL_CRS = 3'h2
    } upm_cpl_t;

    localparam int        UPM_MODE_W      = 3;
    localparam int        UPM_REG_AW      = 6;
    localparam int        UPM_CFG_AW      = 10;
    localparam int        UPM_GAS_DEPTH   = 64;
    localparam logic [9:0] UPM_GASA_ADDR_OFS = 10'h0FE;
    localparam logic [9:0] UPM_GASA_DATA_OFS = 10'h0FF;
    localparam logic [31:0] UPM_DATA_RST  = 32'h0000_0000;
    localparam logic [5:0] UPM_ADDR_RST   = 6'h00;
    localparam logic [2:0] UPM_MODE_RST   = 3'h0;
endpackage

// File: design/upm_regmem.sv
// file: small register memory behind the global address space access window
`timescale 1ns/1ps
module upm_regmem
    import upm_pkg::*;
(
    input  wire logic                  clock_i,   // core clock
    input  wire logic                  wr_en_i,   // write strobe
    input  wire logic [UPM_REG_AW-1:0] addr_i,    // word address
    input  wire logic [31:0]           wdata_i,   // write data
    output logic      [31:0]           rdata_o    // registered read data
);
    logic [31:0] mem [UPM_GAS_DEPTH];

    always_ff @(posedge clock_i) begin
        if (wr_en_i) begin
            mem[addr_i] <= wdata_i;
        end
        rdata_o <= mem[addr_i];
    end
endmodule // upm_regmem

// File: design/upm_port.sv
// file: one switch port running in unattached mode
`timescale 1ns/1ps
module upm_port
    import upm_pkg::*;
(
    input  wire logic                  clock_i,                    // core clock 100 MHz
    input  wire logic                  sys_rst_i,                  // fundamental reset, sync high
    input  wire logic [UPM_MODE_W-1:0] switch_port_control_i,      // mode field of port control
    input  wire logic [UPM_MODE_W-1:0] boot_mode_i,                // boot configuration vector pins
    input  wire logic                  phy_rx_detect_i,            // receiver detected (pin)
    input  wire logic                  phy_trained_i,              // training done (pin)
    input  wire logic                  aspm_enter_i,               // ASPM entry request
    input  wire logic                  dstate_low_i,               // low D-state requested
    input  wire logic                  partition_reset_in_n_i,     // partition reset pin
    input  wire logic                  hotplug_attention_button_n_i, // hot-plug input
    input  wire logic                  hotplug_latch_sense_n_i,    // hot-plug input
    input  wire logic                  hotplug_presence_detect_n_i, // hot-plug input
    input  wire logic                  hotplug_power_fault_n_i,    // hot-plug input
    input  wire logic                  hotplug_power_good_n_i,     // hot-plug input
    input  wire logic                  rx_valid_i,                 // received tlp strobe
    input  wire upm_rx_t               rx_kind_i,                  // received tlp kind
    input  wire logic                  rx_write_i,                 // config write
    input  wire logic [UPM_CFG_AW-1:0] rx_cfg_addr_i,              // config register dword offset
    input  wire logic [31:0]           rx_wdata_i,                 // config write data
    output logic                       serdes_en_o,                // transceiver enable
    output logic                       link_activity_out_n_o,      // activity, low active
    output logic                       link_up_out_n_o,            // link up, low active
    output logic                       hotplug_attention_indicator_o, // negated
    output logic                       hotplug_interlock_out_o,    // negated
    output logic                       hotplug_power_enable_o,     // negated
    output logic                       hotplug_power_indicator_o,  // negated
    output logic                       hotplug_slot_reset_n_o,     // asserted (low)
    output logic                       pm_msg_o,                   // pm message request
    output logic                       int_msg_o,                  // intx/msi request
    output logic                       err_msg_o,                  // error message request
    output logic                       cpl_valid_o,                // completion strobe
    output upm_cpl_t                   cpl_status_o,               // completion status
    output logic [31:0]                cpl_data_o,                 // completion data
    output logic                       fc_return_o,                // credit return strobe
    output logic                       ur_status_o,                // sticky unsupported request
    output logic                       unexp_cpl_o                 // sticky unexpected completion
);
    // ********************
    // input synchronisers
    // ********************
    logic [1:0]            det_s, trn_s;
    logic [UPM_MODE_W-1:0] boot_s0, boot_s1;
    always_ff @(posedge clock_i) begin
        det_s   <= {det_s[0], phy_rx_detect_i};
        trn_s   <= {trn_s[0], phy_trained_i};
        // boot straps are pins too, so they get the same two stages
        boot_s0 <= boot_mode_i;
        boot_s1 <= boot_s0;
    end

    // ********************
    // mode capture
    // ********************
    upm_mode_t boot_mode, next_boot_mode;
    logic      unatt;
    always_comb begin
        next_boot_mode = boot_mode;
        if (sys_rst_i) begin
            next_boot_mode = upm_mode_t'(boot_s1);
        end
    end
    always_ff @(posedge clock_i) begin
        boot_mode <= next_boot_mode;
    end
    // boot vector kept for other modes; unattached decided by the control field
    assign unatt = (upm_mode_t'(switch_port_control_i) == UPM_MODE_UNATTACHED);

    // ********************
    // link training
    // ********************
    upm_lt_t lt, next_lt;
    always_comb begin
        next_lt = lt;
        case (lt)
            UPM_LT_DETECT:   next_lt = det_s[1] ? UPM_LT_TRAINING : UPM_LT_DETECT;
            UPM_LT_TRAINING: next_lt = trn_s[1] ? UPM_LT_L0 : (det_s[1] ? UPM_LT_TRAINING : UPM_LT_DETECT);
            // aspm and d-state requests have no path out of L0
            UPM_LT_L0:       next_lt = det_s[1] ? UPM_LT_L0 : UPM_LT_DETECT;
            default:         next_lt = UPM_LT_DETECT;
        endcase
        if (!unatt) begin
            next_lt = UPM_LT_DETECT;
        end
    end
    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            lt <= UPM_LT_DETECT;
        end else begin
            lt <= next_lt;
        end
    end

    // ********************
    // pins
    // ********************
    logic next_serdes, next_act_n, next_up_n;
    always_comb begin
        next_serdes = unatt;
        next_up_n   = !(unatt && lt == UPM_LT_L0);
        next_act_n  = !(unatt && lt == UPM_LT_L0 && rx_valid_i);
    end
    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            serdes_en_o           <= 1'b0;
            link_up_out_n_o       <= 1'b1;
            link_activity_out_n_o <= 1'b1;
        end else begin
            serdes_en_o           <= next_serdes;
            link_up_out_n_o       <= next_up_n;
            link_activity_out_n_o <= next_act_n;
        end
    end
    // hot-plug, partition and message logic is not built: isolation by construction
    always_ff @(posedge clock_i) begin
        hotplug_attention_indicator_o <= 1'b0;
        hotplug_interlock_out_o       <= 1'b0;
        hotplug_power_enable_o        <= 1'b0;
        hotplug_power_indicator_o     <= 1'b0;
        hotplug_slot_reset_n_o        <= 1'b0;
        pm_msg_o                      <= 1'b0;
        int_msg_o                     <= 1'b0;
        err_msg_o                     <= 1'b0;
    end

    // ********************
    // tlp handling
    // ********************
    logic [UPM_REG_AW-1:0] gas_addr, next_gas_addr;
    logic       take, hit_a, hit_d, mem_wr;
    logic       next_cv, next_fc, next_ur, next_uc, pend_rd, next_pend_rd;
    upm_cpl_t   next_cs;
    logic [31:0] next_cd, mem_rd;

    assign take  = rx_valid_i && unatt && lt == UPM_LT_L0;
    assign hit_a = rx_cfg_addr_i == UPM_GASA_ADDR_OFS;
    assign hit_d = rx_cfg_addr_i == UPM_GASA_DATA_OFS;
    assign mem_wr = take && rx_kind_i == UPM_RX_CFG && hit_d && rx_write_i;

    upm_regmem u_mem (
        .clock_i (clock_i),
        .wr_en_i (mem_wr),
        .addr_i  (gas_addr),
        .wdata_i (rx_wdata_i),
        .rdata_o (mem_rd)
    );

    always_comb begin
        next_gas_addr = gas_addr;
        next_cv = 1'b0;
        next_cs = UPM_CPL_SC;
        next_cd = cpl_data_o;
        next_fc = 1'b0;
        next_ur = ur_status_o;
        next_uc = unexp_cpl_o;
        next_pend_rd = 1'b0;
        if (pend_rd) begin
            next_cv = 1'b1;
            next_cd = mem_rd;
        end else if (take) begin
            case (rx_kind_i)
                UPM_RX_CFG: begin
                    if (hit_a) begin
                        next_cv = 1'b1;
                        next_cd = {26'h0, gas_addr};
                        if (rx_write_i) begin
                            next_gas_addr = rx_wdata_i[UPM_REG_AW-1:0];
                        end
                    end else if (hit_d) begin
                        next_cv = rx_write_i;
                        next_pend_rd = !rx_write_i;
                        next_cd = 32'h0000_0000;
                    end else begin
                        next_cv = 1'b1;
                        next_cs = UPM_CPL_CRS;
                        next_cd = 32'h0000_0000;
                    end
                end
                UPM_RX_REQ: next_ur = 1'b1;
                UPM_RX_NPR: begin
                    next_ur = 1'b1;
                    next_cv = 1'b1;
                    next_cs = UPM_CPL_UR;
                end
                UPM_RX_CPL: begin
                    next_uc = 1'b1;
                    next_fc = 1'b1;
                end
                default: next_cv = 1'b0;
            endcase
        end
    end
    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            gas_addr     <= UPM_ADDR_RST;
            cpl_valid_o  <= 1'b0;
            cpl_status_o <= UPM_CPL_SC;
            cpl_data_o   <= UPM_DATA_RST;
            fc_return_o  <= 1'b0;
            ur_status_o  <= 1'b0;
            unexp_cpl_o  <= 1'b0;
            pend_rd      <= 1'b0;
        end else begin
            gas_addr     <= next_gas_addr;
            cpl_valid_o  <= next_cv;
            cpl_status_o <= next_cs;
            cpl_data_o   <= next_cd;
            fc_return_o  <= next_fc;
            ur_status_o  <= next_ur;
            unexp_cpl_o  <= next_uc;
            pend_rd      <= next_pend_rd;
        end
    end

    // ********************
    // checks
    // ********************
    retry_cpl_a: assert property (@(posedge clock_i) disable iff (sys_rst_i)
        take && rx_kind_i == UPM_RX_CFG && !hit_a && !hit_d && !pend_rd
        |=> cpl_valid_o && cpl_status_o == UPM_CPL_CRS) else $error("retry completion missing");
    data_read_a: assert property (@(posedge clock_i) disable iff (sys_rst_i)
        take && rx_kind_i == UPM_RX_CFG && hit_d && !rx_write_i && !pend_rd
        |=> !cpl_valid_o ##1 cpl_valid_o && cpl_status_o == UPM_CPL_SC) else $error("data read late");
    ur_np_a: assert property (@(posedge clock_i) disable iff (sys_rst_i)
        take && rx_kind_i == UPM_RX_NPR && !pend_rd |=> ur_status_o && cpl_status_o == UPM_CPL_UR)
        else $error("unsupported not flagged");
    cpl_drop_a: assert property (@(posedge clock_i) disable iff (sys_rst_i)
        take && rx_kind_i == UPM_RX_CPL && !pend_rd |=> fc_return_o && unexp_cpl_o && !cpl_valid_o)
        else $error("completion not dropped");
    link_up_a: assert property (@(posedge clock_i) disable iff (sys_rst_i)
        $rose(lt == UPM_LT_L0) |=> !link_up_out_n_o) else $error("link up not shown");
    no_msg_a: assert property (@(posedge clock_i) disable iff (sys_rst_i)
        !pm_msg_o && !int_msg_o && !err_msg_o) else $error("message emitted");
    hp_neg_a: assert property (@(posedge clock_i) disable iff (sys_rst_i)
        ##1 !hotplug_power_enable_o && !hotplug_attention_indicator_o) else $error("hot-plug driven");
    l0_hold_a: assert property (@(posedge clock_i) disable iff (sys_rst_i)
        lt == UPM_LT_L0 && det_s[1] && unatt |=> lt == UPM_LT_L0) else $error("left L0");
    addr_sel_a: assert property (@(posedge clock_i) disable iff (sys_rst_i)
        take && rx_kind_i == UPM_RX_CFG && hit_a && rx_write_i && !pend_rd
        |=> gas_addr == $past(rx_wdata_i[UPM_REG_AW-1:0])) else $error("address not stored");
    cv_retry_c: cover property (@(posedge clock_i) cpl_valid_o && cpl_status_o == UPM_CPL_CRS);
    cv_read_c:  cover property (@(posedge clock_i) pend_rd);
    cv_l0_c:    cover property (@(posedge clock_i) lt == UPM_LT_L0);
endmodule // upm_port

// File: tb/upm_link_partner.sv
// link partner model: detects the receiver, then finishes training
`timescale 1ns/1ps
module upm_link_partner (
    input  wire logic clock_i,         // core clock
    input  wire logic start_i,         // begin link bring-up
    output logic      phy_rx_detect_o, // receiver seen
    output logic      phy_trained_o    // training complete
);
    logic [3:0] cnt = 4'h0;
    always @(posedge clock_i) begin
        if (!start_i) begin
            cnt <= 4'h0;
        end else if (cnt != 4'hF) begin
            cnt <= cnt + 4'h1;
        end
    end
    assign phy_rx_detect_o = start_i;
    // training lags detect by several cycles, like a real partner
    assign phy_trained_o = (cnt > 4'h6);
endmodule // upm_link_partner

// File: tb/tb.sv
// testbench: unattached port against a link partner, queue scoreboard
`timescale 1ns/1ps
module tb;
    import upm_pkg::*;
    logic        clock_i = 1'b0;
    logic        sys_rst_i = 1'b1;
    logic [2:0]  mode = UPM_MODE_UNATTACHED;
    logic [31:0] seed = 32'hD21C;
    logic        rx_valid = 1'b0;
    upm_rx_t     rx_kind = UPM_RX_CFG;
    logic        rx_write = 1'b0;
    logic [9:0]  rx_addr = 10'h000;
    logic [31:0] rx_wdata = 32'h0;
    logic        aspm = 1'b0, dlow = 1'b0, part_n = 1'b1, train = 1'b0, prev_rx = 1'b0;
    logic [4:0]  hp_in = 5'h1F;
    logic [2:0]  boot = 3'h0;
    logic        detect, trained, serdes_en, act_n, up_n, cpl_valid, fc, ur, unexp;
    logic [7:0]  quiet;
    upm_cpl_t    cpl_status;
    logic [31:0] cpl_data;
    logic [31:0] vals [4];
    logic [5:0]  idx [4] = '{6'h00, 6'h3F, 6'h15, 6'h2A};
    logic [35:0] exp_q [$];
    int          err_total = 0, checked = 0, fc_cnt = 0;

    initial begin
        forever #5 clock_i = ~clock_i;
    end

    upm_link_partner u_lp (.clock_i(clock_i), .start_i(train), .phy_rx_detect_o(detect), .phy_trained_o(trained));

    upm_port u_dut (.clock_i(clock_i), .sys_rst_i(sys_rst_i), .switch_port_control_i(mode), .boot_mode_i(boot),
        .phy_rx_detect_i(detect), .phy_trained_i(trained), .aspm_enter_i(aspm), .dstate_low_i(dlow),
        .partition_reset_in_n_i(part_n), .hotplug_attention_button_n_i(hp_in[0]),
        .hotplug_latch_sense_n_i(hp_in[1]), .hotplug_presence_detect_n_i(hp_in[2]),
        .hotplug_power_fault_n_i(hp_in[3]), .hotplug_power_good_n_i(hp_in[4]), .rx_valid_i(rx_valid),
        .rx_kind_i(rx_kind), .rx_write_i(rx_write), .rx_cfg_addr_i(rx_addr), .rx_wdata_i(rx_wdata),
        .serdes_en_o(serdes_en), .link_activity_out_n_o(act_n), .link_up_out_n_o(up_n),
        .hotplug_attention_indicator_o(quiet[0]), .hotplug_interlock_out_o(quiet[1]),
        .hotplug_power_enable_o(quiet[2]), .hotplug_power_indicator_o(quiet[3]),
        .hotplug_slot_reset_n_o(quiet[4]), .pm_msg_o(quiet[5]), .int_msg_o(quiet[6]), .err_msg_o(quiet[7]),
        .cpl_valid_o(cpl_valid), .cpl_status_o(cpl_status), .cpl_data_o(cpl_data), .fc_return_o(fc),
        .ur_status_o(ur), .unexp_cpl_o(unexp));

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            err_total++;
            $display("FAIL %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic send(input upm_rx_t k, input logic w, input logic [9:0] a, input logic [31:0] d);
        @(posedge clock_i);
        rx_valid <= 1'b1;
        rx_kind <= k;
        rx_write <= w;
        rx_addr <= a;
        rx_wdata <= d;
        @(posedge clock_i);
        rx_valid <= 1'b0;
        rx_wdata <= ~d;
        // second idle edge covers the gap after a data-register read
        repeat (2) @(posedge clock_i);
    endtask

    task automatic expect_cpl(input logic chk, input upm_cpl_t st, input logic [31:0] d);
        exp_q.push_back({chk, st, d});
    endtask

    task automatic wait_up;
        int n;
        n = 0;
        while (up_n !== 1'b0 && n < 50) begin
            @(posedge clock_i);
            n++;
        end
        cmp({31'h0, up_n}, 32'h0);
    endtask

    task automatic end_of_test;
        $display("checked %0d err_total %0d", checked, err_total);
        if (err_total == 0 && checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // ignored inputs churn every cycle so any leak shows at the outputs
    always @(posedge clock_i) begin
        seed <= lfsr(seed);
        {aspm, dlow, part_n, hp_in} <= seed[7:0];
        boot <= seed[10:8];
    end

    always @(posedge clock_i) begin
        logic [35:0] e;
        if (!sys_rst_i) begin
            cmp({24'h0, quiet}, 32'h0);
            if (prev_rx && up_n === 1'b0) cmp({31'h0, act_n}, 32'h0);
            if (!prev_rx) cmp({31'h0, act_n}, 32'h1);
            if (fc === 1'b1) fc_cnt++;
            if (cpl_valid === 1'b1) begin
                if (exp_q.size() == 0) begin
                    cmp(32'h1, 32'h0);
                end else begin
                    e = exp_q.pop_front();
                    cmp({29'h0, cpl_status}, {29'h0, e[34:32]});
                    if (e[35]) cmp(cpl_data, e[31:0]);
                end
            end
        end
        prev_rx <= rx_valid;
    end

    initial begin
        repeat (20) @(posedge clock_i);
        sys_rst_i <= 1'b0;
        @(posedge clock_i);
        cmp({31'h0, up_n}, 32'h1);
        train <= 1'b1;
        wait_up;
        cmp({31'h0, serdes_en}, 32'h1);
        // each note goes in before its request: the completion shows while send still runs
        for (int i = 0; i < 4; i++) begin
            vals[i] = lfsr(seed ^ i);
            expect_cpl(1'b0, UPM_CPL_SC, 32'h0);
            send(UPM_RX_CFG, 1'b1, UPM_GASA_ADDR_OFS, {26'h0, idx[i]});
            expect_cpl(1'b0, UPM_CPL_SC, 32'h0);
            send(UPM_RX_CFG, 1'b1, UPM_GASA_DATA_OFS, vals[i]);
        end
        for (int i = 0; i < 4; i++) begin
            expect_cpl(1'b0, UPM_CPL_SC, 32'h0);
            send(UPM_RX_CFG, 1'b1, UPM_GASA_ADDR_OFS, {26'h0, idx[i]});
            expect_cpl(1'b1, UPM_CPL_SC, vals[i]);
            send(UPM_RX_CFG, 1'b0, UPM_GASA_DATA_OFS, 32'h0);
        end
        expect_cpl(1'b1, UPM_CPL_SC, {26'h0, idx[3]});
        send(UPM_RX_CFG, 1'b0, UPM_GASA_ADDR_OFS, 32'h0);
        expect_cpl(1'b0, UPM_CPL_CRS, 32'h0);
        send(UPM_RX_CFG, 1'b0, 10'h004, 32'h0);
        expect_cpl(1'b0, UPM_CPL_CRS, 32'h0);
        send(UPM_RX_CFG, 1'b1, 10'h0FD, 32'h5);
        cmp({31'h0, ur}, 32'h0);
        // posted request first, so only it can have raised the sticky flag
        send(UPM_RX_REQ, 1'b1, 10'h000, 32'h0);
        cmp({31'h0, ur}, 32'h1);
        expect_cpl(1'b0, UPM_CPL_UR, 32'h0);
        send(UPM_RX_NPR, 1'b0, 10'h000, 32'h0);
        send(UPM_RX_CPL, 1'b0, 10'h000, 32'h0);
        send(UPM_RX_CPL, 1'b0, 10'h000, 32'h0);
        cmp({31'h0, unexp}, 32'h1);
        mode <= UPM_MODE_DISABLED;
        send(UPM_RX_CFG, 1'b0, 10'h004, 32'h0);
        cmp({31'h0, up_n}, 32'h1);
        cmp({31'h0, serdes_en}, 32'h0);
        mode <= UPM_MODE_UNATTACHED;
        wait_up;
        expect_cpl(1'b0, UPM_CPL_CRS, 32'h0);
        send(UPM_RX_CFG, 1'b0, 10'h010, 32'h0);
        @(posedge clock_i);
        cmp(fc_cnt, 32'h2);
        cmp(exp_q.size(), 32'h0);
        end_of_test;
    end

    initial begin
        #20000;
        err_total++;
        end_of_test;
    end
endmodule // tb
